//--- inc/drw_pkg.sv
// package for the register write handler of the command-and-response link
// assumes one 100 MHz core clock and a frame decoder that delivers whole words
package drw_pkg;
    // ****************************************
    // frame fields
    // ****************************************
    localparam logic [3:0] CMD_WRITE = 4'h8;
    localparam logic [3:0] GLOBAL_ADDR = 4'h0;
    // byte address of the node address register (upper data byte of the global frame)
    localparam logic [7:0] NODE_ADDR_REG_ADDR = 8'h11;
    // crc-8 polynomial and seed; neutral values, not taken from any real part
    localparam logic [7:0] CRC_POLY = 8'h2f;
    localparam logic [7:0] CRC_SEED = 8'hff;
    // ****************************************
    // register map
    // ****************************************
    localparam int MAP_SIZE = 32;
    localparam logic [7:0] MAP_LAST = 8'h1f;
    // byte addresses at or below this one are read-only
    localparam logic [7:0] RO_LAST = 8'h0f;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] NODE_ADDR_RESET = 4'h0;
    localparam int FRAME_BITS = 24;
    typedef enum logic [1:0] {ST_IDLE, ST_CRC, ST_EXEC, ST_RESP} drw_state_t;
endpackage : drw_pkg

//--- hw/drw_crc8.sv
// serial crc-8 over a 24-bit word, one bit per cycle, msb first
// assumes start is a one-cycle pulse while not busy
module drw_crc8 (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [23:0] word_i,
    output logic done_o,
    output logic [7:0] crc_o
);
    logic [23:0] sh_reg, sh_next;
    logic [7:0] crc_reg, crc_next;
    logic [4:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;

    always_comb begin
        sh_next = sh_reg;
        crc_next = crc_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (start_i) begin
            sh_next = word_i;
            crc_next = drw_pkg::CRC_SEED;
            cnt_next = 5'h00;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            crc_next = {crc_reg[6:0], 1'b0}
                ^ ((crc_reg[7] ^ sh_reg[23]) ? drw_pkg::CRC_POLY : 8'h00);
            sh_next = {sh_reg[22:0], 1'b0};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == 5'(drw_pkg::FRAME_BITS - 1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_reg <= 24'h000000;
            crc_reg <= 8'h00;
            cnt_reg <= 5'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            sh_reg <= sh_next;
            crc_reg <= crc_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign done_o = done_reg;
    assign crc_o = crc_reg;
endmodule : drw_crc8

//--- hw/drw_write_handler.sv
// register write command handler: decode, check, execute, build response
// assumes a frame decoder hands one whole request per valid pulse and a
// transmitter takes the response on a valid pulse
// requests are taken one at a time; a request offered while busy waits
// for ready, since the crc engine is shared between check and response
// Contract
// - request is address nibble, command 1000, byte address, data byte, crc
// - upper data byte holds the target register byte address
// - lower data byte is the value to store
// - wrong node address: no write, no response, except global assignment
// - response carries stored node address and command 1000
// - response data: even register low byte, next register high, after write
// - off-map write changes nothing, response data all zeros
// - read-only write changes nothing, response returns present pair
// - global write accepted only when aimed at the node address register
// - global write accepted only if stored node address is 0000
// - other writes to global address 0000 are ignored
module drw_write_handler (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    // request from frame decoder
    input wire logic REQ_VALID_I,
    input wire logic [31:0] REQ_FRAME_I,
    output logic REQ_READY_O,
    // response to transmitter
    output logic RESP_VALID_O,
    output logic [31:0] RESP_FRAME_O,
    // state seen by the rest of the device
    output logic [3:0] NODE_ADDR_O,
    output logic WRITE_STROBE_O
);
    // ****************************************
    // reset release
    // ****************************************
    logic rst_s1_reg, rst_n;
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // ****************************************
    // frame fields
    // ****************************************
    logic [3:0] frame_phys_addr;
    logic [3:0] frame_cmd;
    logic [7:0] target_byte_addr;
    logic [7:0] frame_wdata;
    logic [7:0] frame_crc;
    logic [31:0] req_reg, req_next;
    assign frame_phys_addr = req_reg[31:28];
    assign frame_cmd = req_reg[27:24];
    assign target_byte_addr = req_reg[23:16];
    assign frame_wdata = req_reg[15:8];
    assign frame_crc = req_reg[7:0];

    // ****************************************
    // register map storage
    // ****************************************
    logic [7:0] regs_reg [drw_pkg::MAP_SIZE];
    logic [3:0] node_address_register;
    logic [3:0] node_next;
    logic wr_en;
    logic [7:0] wr_addr;
    // flat copy of the map so checks can compare the whole map across a cycle
    logic [8*drw_pkg::MAP_SIZE-1:0] regs_flat;

    // the node address lives in its own register, so its map slot is never written
    for (genvar g = 0; g < drw_pkg::MAP_SIZE; g++) begin : g_regs
        always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
            if (!rst_n) begin
                regs_reg[g] <= drw_pkg::REG_RESET;
            end else if (wr_en && wr_addr == 8'(g)
                         && wr_addr != drw_pkg::NODE_ADDR_REG_ADDR) begin
                regs_reg[g] <= frame_wdata;
            end
        end
        assign regs_flat[8*g +: 8] = regs_reg[g];
    end

    // ****************************************
    // control
    // ****************************************
    drw_pkg::drw_state_t st_reg, st_next;
    logic crc_start, crc_done;
    logic [7:0] crc_val;
    logic [31:0] resp_reg, resp_next;
    logic [15:0] pair_data;
    logic [7:0] ev_addr;
    logic in_map, writable, is_global, accept;
    logic crc_ok;
    // crc engine runs once per request and once per response; this flag blocks a second start
    logic busy_flag, busy_next;

    drw_crc8 u_crc (
        .clk_i(CORE_CLK_I),
        .rst_n_i(rst_n),
        .start_i(crc_start),
        .word_i(st_reg == drw_pkg::ST_IDLE ? REQ_FRAME_I[31:8] : resp_reg[31:8]),
        .done_o(crc_done),
        .crc_o(crc_val)
    );

    function automatic logic [7:0] map_read(input logic [7:0] a, input logic [3:0] na,
                                            input logic [7:0] r [drw_pkg::MAP_SIZE]);
        logic [7:0] v;
        v = 8'h00;
        if (a == drw_pkg::NODE_ADDR_REG_ADDR) begin
            v = {4'h0, na};
        end else if (a <= drw_pkg::MAP_LAST) begin
            v = r[a[4:0]];
        end
        return v;
    endfunction : map_read

    assign in_map = target_byte_addr <= drw_pkg::MAP_LAST;
    assign writable = in_map && (target_byte_addr > drw_pkg::RO_LAST);
    assign is_global = frame_phys_addr == drw_pkg::GLOBAL_ADDR;
    assign crc_ok = crc_val == frame_crc;
    // global frames only for node assignment by an unassigned node
    assign accept = frame_cmd == drw_pkg::CMD_WRITE
        && (is_global ? (target_byte_addr == drw_pkg::NODE_ADDR_REG_ADDR
                         && node_address_register == drw_pkg::GLOBAL_ADDR)
                      : frame_phys_addr == node_address_register);
    assign ev_addr = {target_byte_addr[7:1], 1'b0};
    // pair read after the write has landed: exec registers, resp samples next cycle
    assign pair_data = in_map
        ? {map_read(ev_addr + 8'h01, node_address_register, regs_reg),
           map_read(ev_addr, node_address_register, regs_reg)}
        : 16'h0000;

    always_comb begin
        st_next = st_reg;
        req_next = req_reg;
        resp_next = resp_reg;
        node_next = node_address_register;
        crc_start = 1'b0;
        wr_en = 1'b0;
        wr_addr = target_byte_addr;
        unique case (st_reg)
            drw_pkg::ST_IDLE: begin
                if (REQ_VALID_I) begin
                    req_next = REQ_FRAME_I;
                    crc_start = 1'b1;
                    st_next = drw_pkg::ST_CRC;
                end
            end
            drw_pkg::ST_CRC: begin
                // the write and the node update land on the edge that enters exec
                if (crc_done) begin
                    if (crc_ok && accept) begin
                        st_next = drw_pkg::ST_EXEC;
                        wr_en = writable;
                        if (target_byte_addr == drw_pkg::NODE_ADDR_REG_ADDR) begin
                            node_next = frame_wdata[3:0];
                        end
                    end else begin
                        st_next = drw_pkg::ST_IDLE;
                    end
                end
            end
            drw_pkg::ST_EXEC: begin
                // node address after the write, so an assigned node answers with it
                resp_next = {node_address_register, drw_pkg::CMD_WRITE, pair_data, 8'h00};
                st_next = drw_pkg::ST_RESP;
            end
            drw_pkg::ST_RESP: begin
                // the crc byte stays zero only until the response crc lands
                if (resp_reg[7:0] == 8'h00 && !crc_done && !busy_flag) begin
                    crc_start = 1'b1;
                end
                if (crc_done) begin
                    resp_next = {resp_reg[31:8], crc_val};
                    st_next = drw_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // a start in the same cycle as a finish wins, so the flag stays set
    assign busy_next = crc_start ? 1'b1 : (crc_done ? 1'b0 : busy_flag);

    logic resp_v_reg, resp_v_next;
    assign resp_v_next = st_reg == drw_pkg::ST_RESP && crc_done;

    always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= drw_pkg::ST_IDLE;
            req_reg <= 32'h00000000;
            resp_reg <= 32'h00000000;
            node_address_register <= drw_pkg::NODE_ADDR_RESET;
            busy_flag <= 1'b0;
            resp_v_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            req_reg <= req_next;
            resp_reg <= resp_next;
            node_address_register <= node_next;
            busy_flag <= busy_next;
            resp_v_reg <= resp_v_next;
        end
    end

    assign REQ_READY_O = st_reg == drw_pkg::ST_IDLE;
    assign RESP_VALID_O = resp_v_reg;
    assign RESP_FRAME_O = resp_reg;
    assign NODE_ADDR_O = node_address_register;
    assign WRITE_STROBE_O = st_reg == drw_pkg::ST_EXEC;

    // ****************************************
    // checks: filtering
    // ****************************************
    AST_NO_WRITE_ON_MISMATCH: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (st_reg == drw_pkg::ST_CRC && crc_done && !accept) |=> st_reg == drw_pkg::ST_IDLE)
        else $error("mismatched request went on");
    AST_BAD_CRC_DROPPED: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (st_reg == drw_pkg::ST_CRC && crc_done && !crc_ok)
        |=> !WRITE_STROBE_O ##1 !WRITE_STROBE_O)
        else $error("bad crc request executed");
    AST_CMD_FILTER: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (st_reg == drw_pkg::ST_CRC && crc_done && frame_cmd != drw_pkg::CMD_WRITE)
        |=> !WRITE_STROBE_O)
        else $error("other command executed as a write");
    AST_GLOBAL_OTHER_IGNORED: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (st_reg == drw_pkg::ST_CRC && crc_done && is_global
         && target_byte_addr != drw_pkg::NODE_ADDR_REG_ADDR)
        |=> !WRITE_STROBE_O)
        else $error("global write to other register acted on");
    AST_GLOBAL_ONLY_UNASSIGNED: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (WRITE_STROBE_O && is_global) |-> $past(node_address_register) == drw_pkg::GLOBAL_ADDR)
        else $error("global write on assigned node");
    AST_GLOBAL_TARGET: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (WRITE_STROBE_O && is_global) |-> target_byte_addr == drw_pkg::NODE_ADDR_REG_ADDR)
        else $error("global write to other register");

    // ****************************************
    // checks: execution
    // ****************************************
    AST_STORE_VALUE: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (st_reg == drw_pkg::ST_CRC && crc_done && crc_ok && accept && writable
         && target_byte_addr != drw_pkg::NODE_ADDR_REG_ADDR)
        |=> regs_reg[target_byte_addr[4:0]] == frame_wdata)
        else $error("written value not stored");
    AST_NODE_FOLLOWS: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (WRITE_STROBE_O && target_byte_addr == drw_pkg::NODE_ADDR_REG_ADDR)
        |-> NODE_ADDR_O == frame_wdata[3:0])
        else $error("node address not taken");
    AST_OFFMAP_UNCHANGED: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (WRITE_STROBE_O && !in_map)
        |-> $stable(regs_flat) && $stable(node_address_register))
        else $error("off-map write changed the map");
    AST_RO_UNCHANGED: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (WRITE_STROBE_O && in_map && !writable)
        |-> $stable(regs_flat) && $stable(node_address_register))
        else $error("read-only write changed the map");

    // ****************************************
    // checks: response
    // ****************************************
    AST_RESP_HEADER: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        RESP_VALID_O |-> RESP_FRAME_O[31:24] == {NODE_ADDR_O, drw_pkg::CMD_WRITE})
        else $error("response header wrong");
    AST_FRAME_HOLDS: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (st_reg == drw_pkg::ST_IDLE && !RESP_VALID_O) |-> $stable(RESP_FRAME_O))
        else $error("response frame moved while idle");
    AST_RESP_ONLY_EXECUTED: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        RESP_VALID_O |-> $past(st_reg) == drw_pkg::ST_RESP)
        else $error("response without an executed request");
    AST_OFFMAP_ZERO: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (WRITE_STROBE_O && !in_map) |=> RESP_FRAME_O[23:8] == 16'h0000)
        else $error("off-map response not zero");
    AST_PAIR_AFTER_WRITE: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (WRITE_STROBE_O && writable && !target_byte_addr[0]
         && target_byte_addr != drw_pkg::NODE_ADDR_REG_ADDR)
        |=> RESP_FRAME_O[15:8] == frame_wdata)
        else $error("response misses written value");
    AST_PAIR_ODD: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        (WRITE_STROBE_O && writable && target_byte_addr[0]
         && target_byte_addr != drw_pkg::NODE_ADDR_REG_ADDR)
        |=> RESP_FRAME_O[23:16] == frame_wdata)
        else $error("response high byte misses written value");
    AST_CRC_SINGLE_START: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        crc_start |-> !busy_flag)
        else $error("crc engine restarted while busy");
    AST_RESP_WITHIN: assert property (
        @(posedge CORE_CLK_I) disable iff (!rst_n)
        WRITE_STROBE_O |-> ##[2:30] RESP_VALID_O)
        else $error("response late");

    // ****************************************
    // coverage
    // ****************************************
    COV_WRITE: cover property (@(posedge CORE_CLK_I) WRITE_STROBE_O && writable);
    COV_GLOBAL: cover property (@(posedge CORE_CLK_I) WRITE_STROBE_O && is_global);
    COV_OFFMAP: cover property (@(posedge CORE_CLK_I) WRITE_STROBE_O && !in_map);
    COV_READ_ONLY: cover property (@(posedge CORE_CLK_I) WRITE_STROBE_O && in_map && !writable);
    COV_DROPPED: cover property (@(posedge CORE_CLK_I)
        st_reg == drw_pkg::ST_CRC && crc_done && !(crc_ok && accept));
endmodule : drw_write_handler

//--- verif/drw_master_model.sv
// behavioural link master: builds write request words and hands them over
// assumes the handler takes a request on the rising edge where ready is high
module drw_master_model (
    input wire logic clk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [31:0] frame_o
);
    timeunit 1ns;
    timeprecision 1ps;
    bit hung = 1'b0;
    initial begin
        valid_o = 1'b0;
        frame_o = 32'h0000_0000;
    end
    // msb-first crc over address, command and data fields
    function automatic logic [7:0] crc8(input logic [23:0] w);
        logic [7:0] c;
        c = drw_pkg::CRC_SEED;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? drw_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8
    // bad flips the crc lsb so the handler must drop the word
    task automatic send(input logic [3:0] pa, input logic [3:0] cmd,
                        input logic [7:0] ra, input logic [7:0] rd, input bit bad);
        logic [23:0] body;
        int n;
        // a master assigning a node address with a global frame keeps the upper data nibble at zero
        if (pa == drw_pkg::GLOBAL_ADDR && ra == drw_pkg::NODE_ADDR_REG_ADDR) begin
            rd[7:4] = 4'h0;
        end
        body = {pa, cmd, ra, rd};
        n = 0;
        @(posedge clk_i);
        frame_o <= {body, crc8(body) ^ {7'h00, bad}};
        valid_o <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ready_i !== 1'b1 && n < 100);
        hung = hung | (n >= 100);
        valid_o <= 1'b0;
        // released: show the inverse so a stale word is never mistaken for a request
        frame_o <= ~{body, crc8(body)};
    endtask : send
endmodule : drw_master_model

//--- verif/tb_top.sv
// self-checking bench for the register write handler
// assumes drw_pkg constants and the master model; responses checked from a queue
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid, req_ready, resp_valid, write_strobe;
    logic [31:0] req_frame, resp_frame;
    logic [3:0] node_addr;
    logic [7:0] mem [drw_pkg::MAP_SIZE];
    logic [3:0] node = 4'h0;
    logic [31:0] rng = 32'h005d1084;
    logic [31:0] exp_q [$];
    int err_total = 0;
    int samples_checked = 0;
    int strobes = 0;
    int accepted = 0;
    drw_write_handler dut (
        .CORE_CLK_I(core_clk), .RST_N_I(rst_n),
        .REQ_VALID_I(req_valid), .REQ_FRAME_I(req_frame), .REQ_READY_O(req_ready),
        .RESP_VALID_O(resp_valid), .RESP_FRAME_O(resp_frame),
        .NODE_ADDR_O(node_addr), .WRITE_STROBE_O(write_strobe)
    );
    drw_master_model m (
        .clk_i(core_clk), .ready_i(req_ready), .valid_o(req_valid), .frame_o(req_frame)
    );
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd
    function automatic logic [7:0] rd_of(input logic [7:0] a);
        if (a > drw_pkg::MAP_LAST) return 8'h00;
        if (a == drw_pkg::NODE_ADDR_REG_ADDR) return {4'h0, node};
        return mem[a[4:0]];
    endfunction : rd_of
    // ****************************************
    // reference decode, then drive and wait
    // ****************************************
    task automatic op(input logic [3:0] pa, input logic [3:0] cmd,
                      input logic [7:0] ra, input logic [7:0] rd, input bit bad);
        logic acc;
        logic [7:0] ev;
        logic [23:0] body;
        int n;
        acc = (cmd == drw_pkg::CMD_WRITE) && !bad && ((pa == drw_pkg::GLOBAL_ADDR) ?
              (ra == drw_pkg::NODE_ADDR_REG_ADDR && node == 4'h0) : (pa == node));
        if (acc) begin
            accepted++;
            if (ra == drw_pkg::NODE_ADDR_REG_ADDR) node = rd[3:0];
            else if (ra > drw_pkg::RO_LAST && ra <= drw_pkg::MAP_LAST) mem[ra[4:0]] = rd;
            ev = ra & 8'hfe;
            body = {node, drw_pkg::CMD_WRITE, rd_of(ev + 8'h01), rd_of(ev)};
            exp_q.push_back({body, m.crc8(body)});
        end
        m.send(pa, cmd, ra, rd, bad);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        if (n >= 200 || m.hung) begin
            err_total++;
            results();
        end
        chk({28'h0, node_addr}, {28'h0, node});
        repeat (rnd() % 3) @(posedge core_clk);
    endtask : op
    // ****************************************
    // response and strobe watchers
    // ****************************************
    always @(posedge core_clk) begin
        if (rst_n === 1'b1 && write_strobe === 1'b1) strobes++;
        if (rst_n === 1'b1 && resp_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(resp_frame, 32'hxxxx_xxxx);
            else chk(resp_frame, exp_q.pop_front());
        end
    end
    initial begin
        logic [31:0] r;
        foreach (mem[i]) mem[i] = drw_pkg::REG_RESET;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        op(4'h0, drw_pkg::CMD_WRITE, 8'h11, 8'h05, 1'b0);
        op(4'h0, drw_pkg::CMD_WRITE, 8'h11, 8'h03, 1'b0);
        op(4'h0, drw_pkg::CMD_WRITE, 8'h14, 8'h3c, 1'b0);
        op(4'h5, drw_pkg::CMD_WRITE, 8'h14, 8'ha5, 1'b1);
        op(4'h5, 4'h9, 8'h14, 8'ha5, 1'b0);
        op(4'h6, drw_pkg::CMD_WRITE, 8'h14, 8'ha5, 1'b0);
        op(4'h5, drw_pkg::CMD_WRITE, 8'h15, 8'h5a, 1'b0);
        op(4'h5, drw_pkg::CMD_WRITE, 8'h03, 8'hff, 1'b0);
        op(4'h5, drw_pkg::CMD_WRITE, 8'h20, 8'hff, 1'b0);
        repeat (60) begin
            r = rnd();
            op(r[3] ? node : r[7:4], drw_pkg::CMD_WRITE, {2'b00, r[13:8]}, r[23:16],
               r[31:29] == 3'b000);
        end
        // reset in mid-run puts the node address back to zero; two edges first so
        // the watcher has taken the last response off the queue
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b0;
        node = drw_pkg::NODE_ADDR_RESET;
        foreach (mem[i]) mem[i] = drw_pkg::REG_RESET;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({28'h0, node_addr}, 32'h0000_0000);
        op(4'h0, drw_pkg::CMD_WRITE, 8'h11, 8'h0a, 1'b0);
        repeat (5) @(posedge core_clk);
        chk(32'(strobes), 32'(accepted));
        chk(32'(exp_q.size()), 32'h0000_0000);
        results();
    end
endmodule : tb_top
